// File: rtl/prp_pin_logic.sv
/*
  System pin conditioning: reset straps, interrupt inputs, power sense,
  standby control and expansion clock pin steering.
  Assumes all inputs are synchronous to clk_sys_in; processor and
  36.864 MHz clock references arrive as sampled levels.
*/
`timescale 1ns/1ns

module prp_pin_logic (
  input  wire logic                          clk_sys_in,
  input  wire logic                          resetn_in,
  input  wire logic [prp_pkg::CLK_MODE_W-1:0] clk_mode_in,
  input  wire logic                          cpu_clk_level_in,
  input  wire logic                          ref_clk_36m864_level_in,
  input  wire logic                          expansion_clock_pin_in,
  input  wire logic                          media_change_n_in,
  input  wire logic                          external_fast_irq_n_in,
  input  wire logic                          external_irq_high_in,
  input  wire logic [prp_pkg::EIRQ_LOW_N-1:0] external_irq_low_n_in,
  input  wire logic                          power_fail_n_in,
  input  wire logic                          main_battery_good_in,
  input  wire logic                          external_supply_sense_n_in,
  input  wire logic                          new_battery_sense_n_in,
  input  wire logic                          user_reset_n_in,
  input  wire logic [prp_pkg::TEST_W-1:0]    test_in,
  input  wire logic [prp_pkg::PE_W-1:0]      pad_enable_in,
  input  wire logic [prp_pkg::DRIVE_W-1:0]   drive_strength_in,
  input  wire logic                          start_req_in,
  input  wire logic                          battery_fiq_clear_in,
  output logic                               expansion_clock_pin_out,
  output logic                               expansion_clock_pin_oe_out,
  output logic                               sysclk_from_pin_out,
  output logic                               sysclk_pin_level_out,
  output logic                               fast_interrupt_out,
  output logic [prp_pkg::NUM_EIRQ-1:0]       irq_req_out,
  output logic                               battery_fiq_pending_out,
  output logic                               media_change_out,
  output logic                               internal_boot_select_n_out,
  output logic                               user_reset_strap_n_out,
  output logic [prp_pkg::TEST_W-1:0]         test_strap_out,
  output logic [prp_pkg::PE_W-1:0]           pad_enable_strap_out,
  output logic [prp_pkg::DRIVE_W-1:0]        drive_strength_strap_out,
  output logic                               straps_valid_out,
  output logic                               standby_out,
  output logic                               start_refused_out,
  output logic                               new_battery_low_out,
  output logic                               external_power_out
);
  import prp_pkg::*;

  typedef struct packed {
    prp_sys_state_t     st;
    logic               standby;
    logic               refused;
    logic               strap_done;
    logic               boot_sel_n;
    logic               ureset_n;
    logic [TEST_W-1:0]  test;
    logic [PE_W-1:0]    pe;
    logic [DRIVE_W-1:0] drive;
    logic               batt_prev;
    logic               batt_pend;
    logic               fast_interrupt;
    logic               medchg;
    logic [NUM_EIRQ-1:0] irq;
    logic               exp_out;
    logic               exp_oe;
    logic               from_pin;
    logic               pin_lvl;
    logic               batt_low;
    logic               ext_pwr;
  } prp_core_t;

  prp_core_t            s_r;
  prp_core_t            s_nxt;
  logic [NUM_DGL-1:0]   dg_raw;
  logic [NUM_DGL-1:0]   dg_lvl;
  logic                 batt_fall;

  // ****************************************************************
  // deglitched inputs
  // ****************************************************************
  assign dg_raw[DG_MEDCHG]    = media_change_n_in;
  assign dg_raw[DG_PWRFL]     = power_fail_n_in;
  assign dg_raw[DG_BATT_GOOD] = main_battery_good_in;
  assign dg_raw[DG_NEWBATT]   = new_battery_sense_n_in;

  // media change, power fail, battery good and new battery sense
  generate
    for (genvar i = 0; i < NUM_DGL; i++) begin : g_dgl
      prp_deglitch u_dgl (
        .clk_sys_in (clk_sys_in),
        .resetn_in  (resetn_in),
        .raw_in     (dg_raw[i]),
        .level_out  (dg_lvl[i])
      );
    end
  endgenerate

  assign batt_fall = s_r.batt_prev & ~dg_lvl[DG_BATT_GOOD];

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    s_nxt = s_r;

    // straps are caught once, on the first edge after reset release
    if (!s_r.strap_done) begin
      s_nxt.strap_done = 1'b1;
      s_nxt.boot_sel_n = media_change_n_in;
      s_nxt.ureset_n   = user_reset_n_in;
      s_nxt.test       = test_in;
      s_nxt.pe         = pad_enable_in;
      s_nxt.drive      = drive_strength_in;
    end

    // battery falling edge: set wins over software clear
    s_nxt.batt_prev = dg_lvl[DG_BATT_GOOD];
    s_nxt.batt_pend = batt_fall |
                      (s_r.batt_pend & ~battery_fiq_clear_in);

    // media change is a fast interrupt source only after boot select
    s_nxt.medchg = s_r.strap_done & ~dg_lvl[DG_MEDCHG];
    s_nxt.fast_interrupt    = s_nxt.medchg |
                   ~external_fast_irq_n_in |
                   s_nxt.batt_pend;

    s_nxt.irq[EIRQ_HIGH_IDX] = external_irq_high_in;
    for (int k = 0; k < EIRQ_LOW_N; k++) begin
      s_nxt.irq[k] = ~external_irq_low_n_in[k];
    end

    s_nxt.batt_low = ~dg_lvl[DG_NEWBATT];
    s_nxt.ext_pwr  = ~external_supply_sense_n_in;

    // system state
    s_nxt.refused = 1'b0;
    case (s_r.st)
      PRP_ST_STANDBY: begin
        if (start_req_in && !dg_lvl[DG_BATT_GOOD]) begin
          s_nxt.refused = 1'b1;
        end else if (start_req_in && dg_lvl[DG_PWRFL]) begin
          s_nxt.st = PRP_ST_OPERATE;
        end
      end
      PRP_ST_OPERATE: begin
        if (!dg_lvl[DG_PWRFL]) begin
          s_nxt.st = PRP_ST_STANDBY;
        end
      end
      default: begin
        s_nxt.st = PRP_ST_STANDBY;
      end
    endcase
    s_nxt.standby = (s_nxt.st == PRP_ST_STANDBY);

    // expansion clock pin steering
    s_nxt.pin_lvl = expansion_clock_pin_in;
    case (clk_mode_in)
      CLK_MODE_13M: begin
        s_nxt.exp_oe   = 1'b0;
        s_nxt.exp_out  = 1'b0;
        s_nxt.from_pin = 1'b1;
      end
      CLK_MODE_18M: begin
        s_nxt.exp_oe   = 1'b1;
        s_nxt.exp_out  = cpu_clk_level_in;
        s_nxt.from_pin = 1'b0;
      end
      default: begin
        s_nxt.exp_oe   = 1'b1;
        s_nxt.exp_out  = ref_clk_36m864_level_in;
        s_nxt.from_pin = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  // raw power-on reset clears the flops but sets st to standby, standby and batt_prev, with no filtering
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_r <= '0;
      s_r.st        <= PRP_ST_STANDBY;
      s_r.standby   <= 1'b1;
      s_r.batt_prev <= DGL_RESET_LEVEL;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign expansion_clock_pin_out    = s_r.exp_out;
  assign expansion_clock_pin_oe_out = s_r.exp_oe;
  assign sysclk_from_pin_out        = s_r.from_pin;
  assign sysclk_pin_level_out       = s_r.pin_lvl;
  assign fast_interrupt_out         = s_r.fast_interrupt;
  assign irq_req_out                = s_r.irq;
  assign battery_fiq_pending_out    = s_r.batt_pend;
  assign media_change_out           = s_r.medchg;
  assign internal_boot_select_n_out = s_r.boot_sel_n;
  assign user_reset_strap_n_out     = s_r.ureset_n;
  assign test_strap_out             = s_r.test;
  assign pad_enable_strap_out       = s_r.pe;
  assign drive_strength_strap_out   = s_r.drive;
  assign straps_valid_out           = s_r.strap_done;
  assign standby_out                = s_r.standby;
  assign start_refused_out          = s_r.refused;
  assign new_battery_low_out        = s_r.batt_low;
  assign external_power_out         = s_r.ext_pwr;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!resetn_in);

  sequence batt_fall_s;
    dg_lvl[DG_BATT_GOOD] ##1 !dg_lvl[DG_BATT_GOOD];
  endsequence

  sequence refused_start_s;
    standby_out && start_req_in && !dg_lvl[DG_BATT_GOOD];
  endsequence

  sequence strap_catch_s;
    !straps_valid_out ##1 straps_valid_out;
  endsequence

  exp_clk_cpu_a: assert property (
    clk_mode_in == CLK_MODE_18M |=> expansion_clock_pin_oe_out &&
      expansion_clock_pin_out == $past(cpu_clk_level_in))
    else $error("expansion clock not following cpu clock");

  exp_clk_ref_a: assert property (
    (clk_mode_in == CLK_MODE_36M || clk_mode_in == CLK_MODE_49M ||
     clk_mode_in == CLK_MODE_74M) |=> expansion_clock_pin_oe_out &&
      expansion_clock_pin_out == $past(ref_clk_36m864_level_in))
    else $error("expansion clock not following fixed reference");

  exp_clk_input_a: assert property (
    clk_mode_in == CLK_MODE_13M |=>
      !expansion_clock_pin_oe_out && sysclk_from_pin_out)
    else $error("expansion clock pin driven in input mode");

  medchg_fiq_a: assert property (
    straps_valid_out && !dg_lvl[DG_MEDCHG] |=>
      media_change_out && fast_interrupt_out)
    else $error("media change did not request fast interrupt");

  boot_select_a: assert property (
    strap_catch_s |->
      internal_boot_select_n_out == $past(media_change_n_in))
    else $error("boot select not taken from media change pin");

  strap_hold_a: assert property (
    straps_valid_out ##1 straps_valid_out |->
      $stable(internal_boot_select_n_out) && $stable(test_strap_out) &&
      $stable(drive_strength_strap_out) && $stable(user_reset_strap_n_out) &&
      $stable(pad_enable_strap_out))
    else $error("latched strap changed");

  ext_fiq_a: assert property (
    !external_fast_irq_n_in |=> fast_interrupt_out)
    else $error("external fast interrupt missed");

  irq_high_a: assert property (
    external_irq_high_in |=> irq_req_out[EIRQ_HIGH_IDX])
    else $error("active high interrupt missed");

  irq_low_a: assert property (
    external_irq_low_n_in != '1 |=> irq_req_out[EIRQ_LOW_N-1:0] ==
      ~$past(external_irq_low_n_in))
    else $error("active low interrupt mismatch");

  pwrfl_standby_a: assert property (
    !dg_lvl[DG_PWRFL] |=> standby_out)
    else $error("power fail did not force standby");

  batt_fiq_a: assert property (
    batt_fall_s |=> battery_fiq_pending_out && fast_interrupt_out)
    else $error("battery falling edge did not raise fast interrupt");

  start_refuse_a: assert property (
    refused_start_s |=> start_refused_out && standby_out)
    else $error("start not refused with battery low");

  newbatt_sense_a: assert property (
    !dg_lvl[DG_NEWBATT] |=> new_battery_low_out)
    else $error("new battery low not reported");

  refuse_stay_a: assert property (
    standby_out && !dg_lvl[DG_BATT_GOOD] |=> standby_out)
    else $error("system started with battery low");

  sysclk_pin_a: assert property (
    clk_mode_in == CLK_MODE_13M |=>
      sysclk_pin_level_out == $past(expansion_clock_pin_in))
    else $error("system clock level not taken from pin");

endmodule

// File: rtl/prp_pkg.sv
/*
  Shared constants and types for the system pin conditioning logic.
  Assumes one 100 MHz system clock and a raw active-low power-on reset.
*/
// Operation
// - in 18 MHz mode the expansion clock pin follows the processor clock.
// - in 36, 49 and 74 MHz modes the expansion clock pin runs 36.864 MHz.
// - in 13 MHz mode the expansion clock pin is an input clock source.
// - deglitched media change low acts as fast interrupt source in normal use.
// - media change level at power-up picks boot: low internal, high external.
// - boot select, user reset, test and drive straps latched at reset release.
// - low external fast interrupt input requests a fast interrupt.
// - high level on the third external interrupt input requests an interrupt.
// - external interrupt inputs one and two request on a low level.
// - deglitched power fail low forces the system into standby.
// - deglitched battery good falling edge raises a fast interrupt.
// - in standby with battery good low, system start is refused.
// - new battery sense goes low below threshold; it is deglitched.
// - power-on reset is not deglitched; its raw level acts.
// - power-on reset low clears the state and deglitch counters, but sets st to standby, standby, batt_prev and the deglitch sync and level flops.

package prp_pkg;

  // ****************************************************************
  // deglitch filter
  // ****************************************************************
  localparam int            DGL_CNT_W       = 3;
  localparam logic [2:0]    DGL_MAX         = 3'h4;
  localparam logic [2:0]    DGL_CNT_ZERO    = 3'h0;
  localparam logic [2:0]    DGL_CNT_ONE     = 3'h1;
  localparam logic          DGL_RESET_LEVEL = 1'b1;

  // index of each filtered input
  localparam int NUM_DGL      = 4;
  localparam int DG_MEDCHG    = 0;
  localparam int DG_PWRFL     = 1;
  localparam int DG_BATT_GOOD = 2;
  localparam int DG_NEWBATT   = 3;

  // ****************************************************************
  // clock modes
  // ****************************************************************
  localparam int          CLK_MODE_W  = 3;
  localparam logic [2:0]  CLK_MODE_13M = 3'h0;
  localparam logic [2:0]  CLK_MODE_18M = 3'h1;
  localparam logic [2:0]  CLK_MODE_36M = 3'h2;
  localparam logic [2:0]  CLK_MODE_49M = 3'h3;
  localparam logic [2:0]  CLK_MODE_74M = 3'h4;

  // ****************************************************************
  // interrupts and straps
  // ****************************************************************
  localparam int NUM_EIRQ      = 3;
  localparam int EIRQ_HIGH_IDX = 2;
  localparam int EIRQ_LOW_N    = 2;
  localparam int TEST_W        = 2;
  localparam int PE_W          = 3;
  localparam int DRIVE_W       = 2;

  typedef enum logic [1:0] {
    PRP_ST_STANDBY = 2'b01,
    PRP_ST_OPERATE = 2'b10
  } prp_sys_state_t;

endpackage

// File: rtl/prp_deglitch.sv
/*
  One-bit input deglitcher: two-flop synchroniser and stability counter.
  Assumes the input may change at any time relative to clk_sys_in.
*/
`timescale 1ns/1ns

module prp_deglitch (
  input  wire logic clk_sys_in,
  input  wire logic resetn_in,
  input  wire logic raw_in,
  output logic      level_out
);
  import prp_pkg::*;

  typedef struct packed {
    logic                 sync1;
    logic                 sync2;
    logic [DGL_CNT_W-1:0] cnt;
    logic                 level;
  } prp_dgl_t;

  prp_dgl_t s_r;
  prp_dgl_t s_nxt;

  // ****************************************************************
  // filter
  // ****************************************************************
  always_comb begin
    s_nxt       = s_r;
    s_nxt.sync1 = raw_in;
    s_nxt.sync2 = s_r.sync1;
    // a new level must hold for DGL_MAX + 1 cycles before it is taken
    if (s_r.sync2 == s_r.level) begin
      s_nxt.cnt = DGL_CNT_ZERO;
    end else if (s_r.cnt == DGL_MAX) begin
      s_nxt.level = s_r.sync2;
      s_nxt.cnt   = DGL_CNT_ZERO;
    end else begin
      s_nxt.cnt = s_r.cnt + DGL_CNT_ONE;
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_r.sync1 <= DGL_RESET_LEVEL;
      s_r.sync2 <= DGL_RESET_LEVEL;
      s_r.cnt   <= DGL_CNT_ZERO;
      s_r.level <= DGL_RESET_LEVEL;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign level_out = s_r.level;

  // ****************************************************************
  // checks
  // ****************************************************************
  dgl_stable_a: assert property (
    @(posedge clk_sys_in) disable iff (!resetn_in)
    $changed(s_r.level) |-> $past(s_r.cnt) == DGL_MAX)
    else $error("deglitched level changed before stable count");

endmodule

// File: tb/prp_supply_model.sv
/*
  Model of the far side: power supervisor, battery sensing and the
  clock source on the expansion clock pin.
  Assumes bench commands; pins change on the falling clock edge.
*/
`timescale 1ns/1ns

module prp_supply_model
  import prp_pkg::*;
(
  input  wire logic                  clk_sys_in,
  input  wire logic [CLK_MODE_W-1:0] clk_mode_in,
  input  wire logic                  por_req_in,
  input  wire logic                  power_fail_in,
  input  wire logic                  battery_good_in,
  input  wire logic                  on_external_in,
  input  wire logic                  battery_empty_in,
  output logic                       resetn_out,
  output logic                       power_fail_n_out,
  output logic                       main_battery_good_out,
  output logic                       external_supply_sense_n_out,
  output logic                       new_battery_sense_n_out,
  output logic                       expansion_clock_pin_out
);
  initial begin
    resetn_out                  = 1'b0;
    power_fail_n_out            = 1'b1;
    main_battery_good_out       = 1'b1;
    external_supply_sense_n_out = 1'b1;
    new_battery_sense_n_out     = 1'b1;
    expansion_clock_pin_out     = 1'b0;
  end

  // ****************************************************************
  // pin drive
  // ****************************************************************
  always @(negedge clk_sys_in) begin
    // a request lasts one whole cycle at least
    resetn_out                  <= ~por_req_in;
    power_fail_n_out            <= ~power_fail_in;
    main_battery_good_out       <= battery_good_in;
    external_supply_sense_n_out <= ~on_external_in;
    new_battery_sense_n_out     <= ~battery_empty_in;
    // clock is supplied only while the pin is the clock input
    if (clk_mode_in == CLK_MODE_13M) begin
      expansion_clock_pin_out <= ~expansion_clock_pin_out;
    end else begin
      expansion_clock_pin_out <= 1'b0;
    end
  end
endmodule

// File: tb/tb.sv
/*
  Self-checking bench for the system pin conditioning block.
  Assumes the supply model drives reset and power pins; the bench
  drives interrupts, straps and clock levels on the falling edge.
*/
`timescale 1ns/1ns

module tb;
  import prp_pkg::*;
  logic [2:0] clk_mode = 3'h1;
  logic       clk_sys_in = 1'b0, resetn_in, xclk_pin;
  logic       cpu_lvl = 1'b0, ref_lvl = 1'b0, media_n = 1'b1;
  logic       fiq_n = 1'b1, irq_high = 1'b0, ureset_n = 1'b1;
  logic [1:0] irq_low_n = 2'h3, test_v = 2'h0, drive_v = 2'h0;
  logic [2:0] pe_v = 3'h0;
  logic       start_req = 1'b0, fiq_clear = 1'b0, por_req = 1'b1;
  logic       pwr_fail = 1'b0, batt_good = 1'b1, on_ext = 1'b0;
  logic       batt_empty = 1'b0, pf_n, bg, es_n, nb_n, xo, xoe, from_pin;
  logic       pin_lvl, fi, pend, mc_out, boot_n, ur_s, valid, stby;
  logic       refused, nb_low, ext_pwr, seen;
  logic [2:0] irq, pe_s;
  logic [1:0] test_s, drv_s;
  logic [7:0] straps_exp;
  integer     seed = 24;
  int         err_total = 0, total_checks = 0;

  always #5 clk_sys_in = ~clk_sys_in;

  prp_supply_model model (.clk_sys_in(clk_sys_in), .clk_mode_in(clk_mode),
    .por_req_in(por_req), .power_fail_in(pwr_fail),
    .battery_good_in(batt_good), .on_external_in(on_ext),
    .battery_empty_in(batt_empty), .resetn_out(resetn_in),
    .power_fail_n_out(pf_n), .main_battery_good_out(bg),
    .external_supply_sense_n_out(es_n), .new_battery_sense_n_out(nb_n),
    .expansion_clock_pin_out(xclk_pin));

  prp_pin_logic dut (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
    .clk_mode_in(clk_mode), .cpu_clk_level_in(cpu_lvl),
    .ref_clk_36m864_level_in(ref_lvl), .expansion_clock_pin_in(xclk_pin),
    .media_change_n_in(media_n), .external_fast_irq_n_in(fiq_n),
    .external_irq_high_in(irq_high), .external_irq_low_n_in(irq_low_n),
    .power_fail_n_in(pf_n), .main_battery_good_in(bg),
    .external_supply_sense_n_in(es_n), .new_battery_sense_n_in(nb_n),
    .user_reset_n_in(ureset_n), .test_in(test_v), .pad_enable_in(pe_v),
    .drive_strength_in(drive_v), .start_req_in(start_req),
    .battery_fiq_clear_in(fiq_clear), .expansion_clock_pin_out(xo),
    .expansion_clock_pin_oe_out(xoe), .sysclk_from_pin_out(from_pin),
    .sysclk_pin_level_out(pin_lvl), .fast_interrupt_out(fi),
    .irq_req_out(irq), .battery_fiq_pending_out(pend),
    .media_change_out(mc_out), .internal_boot_select_n_out(boot_n),
    .user_reset_strap_n_out(ur_s), .test_strap_out(test_s),
    .pad_enable_strap_out(pe_s), .drive_strength_strap_out(drv_s),
    .straps_valid_out(valid), .standby_out(stby),
    .start_refused_out(refused), .new_battery_low_out(nb_low),
    .external_power_out(ext_pwr));

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [2:0] exp_irq(logic h, logic [1:0] l_n);
    return {h, ~l_n};
  endfunction

  function automatic logic [1:0] exp_xclk(logic [2:0] m, logic c, logic r);
    if (m == CLK_MODE_13M) return 2'b00;
    return {1'b1, (m == CLK_MODE_18M) ? c : r};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask

  task automatic reset_straps(input logic boot);
    {ureset_n, test_v, pe_v, drive_v} <= 8'($random(seed));
    media_n <= boot;
    cyc(1);
    straps_exp = {ureset_n, test_v, pe_v, drive_v};
  endtask

  task automatic test_done;
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys_in);
    err_total++;
    test_done();
  end

  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    reset_straps(1'b1);
    cyc(8);
    chk({stby, fi, valid, irq}, 8'h20);
    cyc(6);
    por_req <= 1'b0;
    cyc(4);
    {ureset_n, test_v, pe_v, drive_v} <= ~straps_exp;
    media_n <= 1'b1;
    cyc(3);
    chk({ur_s, test_s, pe_s, drv_s}, straps_exp);
    chk({valid, boot_n}, 8'h03);
    // interrupt inputs, random levels
    repeat (24) begin
      {fiq_n, irq_high, irq_low_n} <= 4'($random(seed));
      cyc(3);
      chk(irq, exp_irq(irq_high, irq_low_n));
      chk(fi, {~fiq_n});
    end
    {fiq_n, irq_high, irq_low_n} <= 4'hb;
    // expansion clock pin in every mode
    for (int m = 0; m < 5; m++) begin
      repeat (3) begin
        clk_mode <= 3'(m);
        {cpu_lvl, ref_lvl} <= 2'($random(seed));
        cyc(3);
        chk({xoe, (m == 0) ? 1'b0 : xo},
            exp_xclk(3'(m), cpu_lvl, ref_lvl));
        chk(from_pin, m == 0);
        chk(pin_lvl, xclk_pin);
      end
    end
    clk_mode <= CLK_MODE_18M;
    // media change: glitch dropped, stable low accepted
    media_n <= 1'b0;
    cyc(2);
    media_n <= 1'b1;
    cyc(10);
    chk(fi, 1'b0);
    media_n <= 1'b0;
    cyc(3);
    chk(fi, 1'b0);
    cyc(9);
    chk({fi, mc_out}, 8'h03);
    media_n <= 1'b1;
    // battery fall, refused start, clear
    batt_good <= 1'b0;
    cyc(13);
    chk({pend, fi}, 8'h03);
    start_req <= 1'b1;
    seen = 1'b0;
    repeat (4) begin
      cyc(1);
      start_req <= 1'b0;
      seen = seen | (refused === 1'b1);
    end
    chk({seen, stby}, 8'h03);
    fiq_clear <= 1'b1;
    cyc(1);
    fiq_clear <= 1'b0;
    cyc(2);
    chk({pend, fi}, 8'h00);
    // good battery: start, then power fail to standby
    batt_good <= 1'b1;
    cyc(13);
    start_req <= 1'b1;
    cyc(1);
    start_req <= 1'b0;
    cyc(3);
    chk(stby, 1'b0);
    pwr_fail <= 1'b1;
    cyc(4);
    chk(stby, 1'b0);
    cyc(10);
    chk(stby, 1'b1);
    pwr_fail <= 1'b0;
    // sense inputs
    on_ext <= 1'b1;
    batt_empty <= 1'b1;
    cyc(14);
    chk({nb_low, ext_pwr}, 8'h03);
    // one-cycle reset in mid-run, internal boot
    irq_high <= 1'b1;
    reset_straps(1'b0);
    por_req <= 1'b1;
    cyc(1);
    por_req <= 1'b0;
    cyc(1);
    chk({stby, valid, irq}, 8'h10);
    cyc(3);
    chk({ur_s, test_s, pe_s, drv_s}, straps_exp);
    chk({valid, boot_n}, 8'h02);
    test_done();
  end
endmodule
